// ===== logic/fla_flash_ctrl.sv
// What this block does
// RQ1: Outside download mode, code memory is read-only.
// RQ2: Download mode lets software rewrite lower region.
// RQ3: Bootload top region never writable by software.
// RQ4: Smaller variant bootload region starts at 6000H.
// RQ5: Smallest variant has no download mode.
// RQ6: Three protection modes, each set independently.
// RQ7: Lock blocks parallel writes, allows reads.
// RQ8: Secure blocks parallel writes, reads, external fetches.
// RQ9: Code-and-data erase clears lock and secure.
// RQ10: Serial-safe turns strap reset into normal reset.
// RQ11: Only parallel erase clears serial-safe.
// RQ12: Data memory is 1024 four-byte pages.
// RQ13: Four data registers hold addressed page.
// RQ14: Command register triggers nine operations.
// RQ15: Mode selects data or code memory target.
// RQ16: Normal-mode read, write, erase, byte commands.
// RQ17: Verify leaves zero on match, nonzero otherwise.
// RQ18: F0H enters, 0FH leaves download mode.
// RQ19: Software erases before programming a byte.
`default_nettype none
module fla_flash_ctrl import fla_pkg::*; #(
    parameter logic [1:0] MEM_VARIANT = FLA_VAR_62K
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire fla_sfr_s sfrReq,
    output logic [7:0] sfrRdata,
    output logic busy,
    output logic uloadActive,
    input wire logic program_store_strobe_n,
    output logic serialDownloadEntry,
    input wire logic secProgram,
    input wire fla_sec_s secWrite,
    output fla_sec_s secState,
    input wire logic eraseCodeDataPar,
    input wire logic eraseCodeDataSer,
    input wire logic ppWrite,
    input wire logic [15:0] ppAddr,
    input wire logic [7:0] ppWdata,
    output logic [7:0] ppRdata,
    input wire logic sdWrite,
    input wire logic [15:0] sdAddr,
    input wire logic [7:0] sdWdata,
    input wire logic [15:0] fetchAddr,
    input wire logic fetchExternal,
    output logic [7:0] fetchData
);
    localparam logic [15:0] PROG_END = fla_prog_end(MEM_VARIANT);
    localparam logic [15:0] UL_TOP = fla_ul_top(MEM_VARIANT); // RQ4

    fla_state_e st_q, st_d;
    logic [15:0] cnt_q, cnt_d, last_q, last_d;
    logic tgtProg_q, tgtProg_d, single_q, single_d, mism_q, mism_d;
    logic user_download_mode_q, user_download_mode_d;
    logic [7:0] cmd_q, cmd_d, addrH_q, addrH_d, addrL_q, addrL_d;
    logic [3:0][7:0] pd_q, pd_d;
    logic [7:0] sfrRdata_q, sfrRdata_d, fetch_q, fetch_d, ppRd_q, ppRd_d;

    logic [15:0] byteAddr, pageBase, ulPage;
    logic [1:0] idx;
    logic [7:0] memRd, dataRd, progRdA, progRdB, fsmWdata, progWdata;
    logic fsmDataWe, fsmProgWe, extWe, progWe, eraseGo, cmdWrite;
    logic [15:0] progWaddr;

    // Erase control from the serial kernel or parallel programmer, and the software command write
    assign eraseGo = (eraseCodeDataPar || eraseCodeDataSer) && st_q == FLA_IDLE;
    assign cmdWrite = sfrReq.write && sfrReq.addr == FLA_SFR_CMD && st_q == FLA_IDLE
        && !eraseGo;

    fla_security u_sec (
        .clk(clk),
        .reset_n(reset_n),
        .program_store_strobe_n(program_store_strobe_n),
        .secProgram(secProgram),
        .secWrite(secWrite),
        .eraseParallel(eraseCodeDataPar && eraseGo),
        .eraseSerial(eraseCodeDataSer && eraseGo),
        .secState(secState),
        .serialDownloadEntry(serialDownloadEntry)
    );

    assign byteAddr = {addrH_q, addrL_q};
    assign pageBase = {4'h0, byteAddr[9:0], 2'b00}; // RQ12
    assign ulPage = {byteAddr[15:6], 6'h00};
    assign idx = single_q ? 2'h0 : cnt_q[1:0]; // RQ13
    assign memRd = tgtProg_q ? progRdB : dataRd; // RQ15

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        last_d = last_q;
        tgtProg_d = tgtProg_q;
        single_d = single_q;
        mism_d = mism_q;
        user_download_mode_d = user_download_mode_q;
        cmd_d = cmd_q;
        addrH_d = addrH_q;
        addrL_d = addrL_q;
        pd_d = pd_q;
        fsmDataWe = 1'b0;
        fsmProgWe = 1'b0;
        fsmWdata = FLA_ERASED;
        case (st_q)
            FLA_IDLE: begin
                if (eraseGo) begin
                    st_d = FLA_CHIP_ERASE;
                    cnt_d = '0;
                    last_d = PROG_END - 16'h1;
                end else if (sfrReq.write) begin
                    case (sfrReq.addr)
                        FLA_SFR_DATA1: pd_d[0] = sfrReq.wdata;
                        FLA_SFR_DATA2: pd_d[1] = sfrReq.wdata;
                        FLA_SFR_DATA3: pd_d[2] = sfrReq.wdata;
                        FLA_SFR_DATA4: pd_d[3] = sfrReq.wdata;
                        FLA_SFR_ADDRH: addrH_d = sfrReq.wdata;
                        FLA_SFR_ADDRL: addrL_d = sfrReq.wdata;
                        default: ;
                    endcase
                end
                if (cmdWrite) begin // RQ14
                    cmd_d = sfrReq.wdata;
                    tgtProg_d = user_download_mode_q;
                    single_d = 1'b0;
                    mism_d = 1'b0;
                    cnt_d = pageBase;
                    last_d = pageBase + FLA_DATA_PAGE_LAST;
                    case (sfrReq.wdata)
                        FLA_CMD_ENTER_UL: user_download_mode_d = UL_TOP != 16'h0000; // RQ18 RQ5
                        FLA_CMD_LEAVE_UL: user_download_mode_d = 1'b0; // RQ18
                        FLA_CMD_READ_PAGE: st_d = user_download_mode_q ? FLA_IDLE : FLA_READ; // RQ16
                        FLA_CMD_WRITE_PAGE: st_d = user_download_mode_q ? FLA_IDLE : FLA_WRITE;
                        FLA_CMD_VERIFY: st_d = user_download_mode_q ? FLA_IDLE : FLA_VERIFY; // RQ17
                        FLA_CMD_READ_BYTE: begin
                            st_d = user_download_mode_q ? FLA_IDLE : FLA_READ;
                            single_d = 1'b1;
                            cnt_d = {4'h0, byteAddr[11:0]};
                            last_d = {4'h0, byteAddr[11:0]};
                        end
                        FLA_CMD_WRITE_BYTE: begin
                            single_d = 1'b1;
                            if (user_download_mode_q) begin
                                st_d = byteAddr < UL_TOP ? FLA_WRITE : FLA_IDLE; // RQ2 RQ3
                                cnt_d = byteAddr;
                                last_d = byteAddr;
                            end else begin
                                st_d = FLA_WRITE;
                                cnt_d = {4'h0, byteAddr[11:0]};
                                last_d = {4'h0, byteAddr[11:0]};
                            end
                        end
                        FLA_CMD_ERASE_PAGE: begin
                            if (user_download_mode_q) begin
                                st_d = ulPage < UL_TOP ? FLA_ERASE : FLA_IDLE; // RQ2 RQ3
                                cnt_d = ulPage;
                                last_d = ulPage + FLA_UL_PAGE_LAST;
                            end else begin
                                st_d = FLA_ERASE; // RQ16
                            end
                        end
                        FLA_CMD_ERASE_ALL: begin
                            st_d = FLA_ERASE;
                            cnt_d = '0;
                            last_d = user_download_mode_q ? UL_TOP - 16'h1 : FLA_DATA_LAST; // RQ2
                        end
                        default: ;
                    endcase
                end
            end
            FLA_READ: begin
                pd_d[idx] = memRd;
                st_d = cnt_q == last_q ? FLA_IDLE : FLA_READ;
                cnt_d = cnt_q + 16'h1;
            end
            FLA_WRITE, FLA_ERASE: begin
                // Programming can only clear bits, so unerased cells keep zeros
                fsmWdata = st_q == FLA_WRITE ? (memRd & pd_q[idx]) : FLA_ERASED; // RQ19
                fsmDataWe = !tgtProg_q;
                fsmProgWe = tgtProg_q; // RQ1
                st_d = cnt_q == last_q ? FLA_IDLE : st_q;
                cnt_d = cnt_q + 16'h1;
            end
            FLA_VERIFY: begin
                mism_d = mism_q || memRd != pd_q[idx];
                if (cnt_q == last_q) begin
                    st_d = FLA_IDLE;
                    cmd_d = mism_d ? FLA_CMD_FAIL : FLA_CMD_OK; // RQ17
                end
                cnt_d = cnt_q + 16'h1;
            end
            FLA_CHIP_ERASE: begin
                // Code and data cleared together; data finishes first
                fsmProgWe = 1'b1;
                fsmDataWe = cnt_q <= FLA_DATA_LAST;
                st_d = cnt_q == last_q ? FLA_IDLE : FLA_CHIP_ERASE;
                cnt_d = cnt_q + 16'h1;
            end
            default: st_d = FLA_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= FLA_IDLE;
            cnt_q <= '0;
            last_q <= '0;
            tgtProg_q <= 1'b0;
            single_q <= 1'b0;
            mism_q <= 1'b0;
            user_download_mode_q <= 1'b0;
            cmd_q <= FLA_REG_RESET;
            addrH_q <= FLA_REG_RESET;
            addrL_q <= FLA_REG_RESET;
            pd_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
            tgtProg_q <= tgtProg_d;
            single_q <= single_d;
            mism_q <= mism_d;
            user_download_mode_q <= user_download_mode_d;
            cmd_q <= cmd_d;
            addrH_q <= addrH_d;
            addrL_q <= addrL_d;
            pd_q <= pd_d;
        end
    end

    // External tools write code only while software is not using the array
    assign extWe = st_q == FLA_IDLE && ((ppWrite && !secState.lock && !secState.secure) // RQ7 RQ8
        || sdWrite) && ((ppWrite ? ppAddr : sdAddr) < PROG_END);
    assign progWe = fsmProgWe || extWe;
    assign progWaddr = fsmProgWe ? cnt_q : (ppWrite ? ppAddr : sdAddr);
    assign progWdata = fsmProgWe ? fsmWdata : (ppWrite ? ppWdata : sdWdata);

    fla_nv_array #(.DEPTH(FLA_PROG_DEPTH), .AW(FLA_PROG_AW)) u_prog (
        .clk(clk),
        .we(progWe),
        .waddr(progWaddr),
        .wdata(progWdata),
        .raddrA(fetchAddr),
        .rdataA(progRdA),
        .raddrB(st_q == FLA_IDLE ? ppAddr : cnt_q),
        .rdataB(progRdB)
    );

    fla_nv_array #(.DEPTH(FLA_DATA_DEPTH), .AW(FLA_DATA_AW)) u_data (
        .clk(clk),
        .we(fsmDataWe),
        .waddr(cnt_q[11:0]),
        .wdata(fsmWdata),
        .raddrA(cnt_q[11:0]),
        .rdataA(dataRd),
        .raddrB(cnt_q[11:0]),
        .rdataB()
    );

    always_comb begin
        sfrRdata_d = sfrRdata_q;
        if (sfrReq.read) begin
            case (sfrReq.addr)
                FLA_SFR_CMD: sfrRdata_d = cmd_q;
                FLA_SFR_DATA1: sfrRdata_d = pd_q[0];
                FLA_SFR_DATA2: sfrRdata_d = pd_q[1];
                FLA_SFR_DATA3: sfrRdata_d = pd_q[2];
                FLA_SFR_DATA4: sfrRdata_d = pd_q[3];
                FLA_SFR_ADDRH: sfrRdata_d = addrH_q;
                FLA_SFR_ADDRL: sfrRdata_d = addrL_q;
                default: sfrRdata_d = FLA_REG_RESET;
            endcase
        end
        // Hidden firmware area and secured external fetches read as zero
        fetch_d = (fetchAddr >= PROG_END || (secState.secure && fetchExternal)) ? 8'h00
            : progRdA; // RQ8
        ppRd_d = secState.secure ? 8'h00 : progRdB; // RQ7 RQ8
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfrRdata_q <= FLA_REG_RESET;
            fetch_q <= FLA_REG_RESET;
            ppRd_q <= FLA_REG_RESET;
        end else begin
            sfrRdata_q <= sfrRdata_d;
            fetch_q <= fetch_d;
            ppRd_q <= ppRd_d;
        end
    end

    assign sfrRdata = sfrRdata_q;
    assign fetchData = fetch_q;
    assign ppRdata = ppRd_q;
    assign busy = st_q != FLA_IDLE;
    assign uloadActive = user_download_mode_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_code_ro_normal;
        (fsmProgWe && st_q != FLA_CHIP_ERASE) |-> user_download_mode_q && tgtProg_q;
    endproperty
    a_code_ro_normal: assert property (p_code_ro_normal) // RQ1
        else $error("code memory written by software outside download mode");

    property p_boot_protected;
        (fsmProgWe && st_q != FLA_CHIP_ERASE) |-> cnt_q < UL_TOP;
    endproperty
    a_boot_protected: assert property (p_boot_protected) // RQ3
        else $error("software wrote the bootload region");

    property p_no_user_download_mode_small;
        (MEM_VARIANT == FLA_VAR_8K) |-> !user_download_mode_q;
    endproperty
    a_no_user_download_mode_small: assert property (p_no_user_download_mode_small) // RQ5
        else $error("download mode active on smallest variant");

    property p_lock_blocks_pp;
        (ppWrite && !sdWrite && (secState.lock || secState.secure)) |-> !extWe;
    endproperty
    a_lock_blocks_pp: assert property (p_lock_blocks_pp) // RQ7
        else $error("parallel write accepted while locked");

    property p_secure_fetch;
        (secState.secure && fetchExternal) |=> fetchData == 8'h00;
    endproperty
    a_secure_fetch: assert property (p_secure_fetch) // RQ8
        else $error("external fetch returned data in secure mode");

    property p_page_read_len;
        (cmdWrite && !user_download_mode_q && sfrReq.wdata == FLA_CMD_READ_PAGE)
            |=> (st_q == FLA_READ) [*4] ##1 (st_q == FLA_IDLE);
    endproperty
    a_page_read_len: assert property (p_page_read_len) // RQ16
        else $error("page read did not take four cycles");

    property p_verify_fail;
        (st_q == FLA_VERIFY && memRd != pd_q[idx])
            |-> ##[1:4] (st_q == FLA_IDLE && cmd_q == FLA_CMD_FAIL);
    endproperty
    a_verify_fail: assert property (p_verify_fail) // RQ17
        else $error("verify mismatch not reported");

    property p_enter_user_download_mode;
        (cmdWrite && sfrReq.wdata == FLA_CMD_ENTER_UL && MEM_VARIANT != FLA_VAR_8K)
            |=> user_download_mode_q ##1 user_download_mode_q || $past(cmdWrite);
    endproperty
    a_enter_user_download_mode: assert property (p_enter_user_download_mode) // RQ18
        else $error("download mode not entered");
endmodule
`default_nettype wire

// ===== logic/fla_nv_array.sv
`default_nettype none
module fla_nv_array import fla_pkg::*; #(
    parameter int DEPTH = FLA_DATA_DEPTH,
    parameter int AW = FLA_DATA_AW
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddrA,
    output logic [7:0] rdataA,
    input wire logic [AW-1:0] raddrB,
    output logic [7:0] rdataB
);
    // Cell contents are not reset: they model nonvolatile storage
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdataA = mem[raddrA];
    assign rdataB = mem[raddrB];
endmodule
`default_nettype wire

// ===== logic/fla_pkg.sv
`default_nettype none
package fla_pkg;
    // Program memory size options
    localparam logic [1:0] FLA_VAR_62K = 2'h0;
    localparam logic [1:0] FLA_VAR_32K = 2'h1;
    localparam logic [1:0] FLA_VAR_8K = 2'h2;

    localparam int FLA_PROG_DEPTH = 65536;
    localparam int FLA_PROG_AW = 16;
    localparam int FLA_DATA_DEPTH = 4096;
    localparam int FLA_DATA_AW = 12;

    // End of user code space, start of the protected bootload area
    localparam logic [15:0] FLA_PROG_END_62K = 16'hf800;
    localparam logic [15:0] FLA_PROG_END_32K = 16'h8000;
    localparam logic [15:0] FLA_PROG_END_8K = 16'h2000;
    localparam logic [15:0] FLA_UL_TOP_62K = 16'he000;
    localparam logic [15:0] FLA_UL_TOP_32K = 16'h6000;
    localparam logic [15:0] FLA_UL_TOP_8K = 16'h0000;
    localparam logic [15:0] FLA_DATA_LAST = 16'h0fff;
    localparam logic [15:0] FLA_DATA_PAGE_LAST = 16'h0003;
    localparam logic [15:0] FLA_UL_PAGE_LAST = 16'h003f;

    // Register addresses
    localparam logic [7:0] FLA_SFR_CMD = 8'h00;
    localparam logic [7:0] FLA_SFR_DATA1 = 8'h01;
    localparam logic [7:0] FLA_SFR_DATA2 = 8'h02;
    localparam logic [7:0] FLA_SFR_DATA3 = 8'h03;
    localparam logic [7:0] FLA_SFR_DATA4 = 8'h04;
    localparam logic [7:0] FLA_SFR_ADDRH = 8'h05;
    localparam logic [7:0] FLA_SFR_ADDRL = 8'h06;

    // Command codes
    localparam logic [7:0] FLA_CMD_READ_PAGE = 8'h01;
    localparam logic [7:0] FLA_CMD_WRITE_PAGE = 8'h02;
    localparam logic [7:0] FLA_CMD_VERIFY = 8'h04;
    localparam logic [7:0] FLA_CMD_ERASE_PAGE = 8'h05;
    localparam logic [7:0] FLA_CMD_ERASE_ALL = 8'h06;
    localparam logic [7:0] FLA_CMD_READ_BYTE = 8'h81;
    localparam logic [7:0] FLA_CMD_WRITE_BYTE = 8'h82;
    localparam logic [7:0] FLA_CMD_LEAVE_UL = 8'h0f;
    localparam logic [7:0] FLA_CMD_ENTER_UL = 8'hf0;
    localparam logic [7:0] FLA_CMD_OK = 8'h00;
    localparam logic [7:0] FLA_CMD_FAIL = 8'h01;

    localparam logic [7:0] FLA_REG_RESET = 8'h00;
    localparam logic [7:0] FLA_ERASED = 8'hff;
    localparam logic [1:0] FLA_BOOT_WAIT = 2'h3;

    typedef enum logic [2:0] {
        FLA_IDLE, FLA_READ, FLA_WRITE, FLA_VERIFY, FLA_ERASE, FLA_CHIP_ERASE
    } fla_state_e;

    typedef struct packed {
        logic lock;
        logic secure;
        logic serialSafe;
    } fla_sec_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fla_sfr_s;

    function automatic logic [15:0] fla_prog_end(input logic [1:0] v);
        case (v)
            FLA_VAR_32K: return FLA_PROG_END_32K;
            FLA_VAR_8K: return FLA_PROG_END_8K;
            default: return FLA_PROG_END_62K;
        endcase
    endfunction

    function automatic logic [15:0] fla_ul_top(input logic [1:0] v);
        case (v)
            FLA_VAR_32K: return FLA_UL_TOP_32K;
            FLA_VAR_8K: return FLA_UL_TOP_8K;
            default: return FLA_UL_TOP_62K;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== logic/fla_security.sv
`default_nettype none
module fla_security import fla_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic program_store_strobe_n,
    input wire logic secProgram,
    input wire fla_sec_s secWrite,
    input wire logic eraseParallel,
    input wire logic eraseSerial,
    output fla_sec_s secState,
    output logic serialDownloadEntry
);
    // Stand-in for nonvolatile protection cells: reset leaves them alone
    fla_sec_s sec_q = '0;
    fla_sec_s sec_d;
    logic strobeMeta_q, strobeSync_q;
    logic [1:0] boot_q, boot_d;
    logic entry_q, entry_d;

    always_comb begin
        sec_d = sec_q;
        if (eraseParallel) begin
            sec_d = '0; // RQ11
        end
        if (eraseSerial) begin
            sec_d.lock = 1'b0; // RQ9
            sec_d.secure = 1'b0;
        end
        // Programming only sets bits, and wins over a clear in the same cycle
        if (secProgram) begin
            sec_d = sec_d | secWrite; // RQ6
        end
    end

    always_comb begin
        boot_d = boot_q;
        entry_d = entry_q;
        if (boot_q != FLA_BOOT_WAIT) begin
            boot_d = boot_q + 2'h1;
        end
        // Strap is judged once the synchroniser holds a post-reset level
        if (boot_q == FLA_BOOT_WAIT - 2'h1) begin
            entry_d = !strobeSync_q && !sec_q.serialSafe; // RQ10
        end
    end

    // Only an erase may clear the bits, so no reset branch here
    always_ff @(posedge clk) begin
        sec_q <= sec_d; // RQ9 RQ11
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobeMeta_q <= 1'b1;
            strobeSync_q <= 1'b1;
            boot_q <= 2'h0;
            entry_q <= 1'b0;
        end else begin
            strobeMeta_q <= program_store_strobe_n;
            strobeSync_q <= strobeMeta_q;
            boot_q <= boot_d;
            entry_q <= entry_d;
        end
    end

    assign secState = sec_q;
    assign serialDownloadEntry = entry_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_safe_blocks_entry;
        $rose(entry_q) |-> !$past(sec_q.serialSafe);
    endproperty
    a_safe_blocks_entry: assert property (p_safe_blocks_entry) // RQ10
        else $error("serial download entered while serial-safe set");

    property p_serial_keeps_safe;
        (eraseSerial && !eraseParallel && !secProgram) |=> sec_q.serialSafe == $past(sec_q.serialSafe);
    endproperty
    a_serial_keeps_safe: assert property (p_serial_keeps_safe) // RQ11
        else $error("serial erase changed serial-safe mode");

    property p_erase_clears_lock;
        (eraseSerial && !secProgram) |=> !sec_q.lock && !sec_q.secure;
    endproperty
    a_erase_clears_lock: assert property (p_erase_clears_lock) // RQ9
        else $error("erase code and data left lock or secure set");
endmodule
`default_nettype wire

// ===== sim/fla_prog_model.sv
`default_nettype none
module fla_prog_model import fla_pkg::*; (
    input wire logic clk,
    output logic ppWrite,
    output logic sdWrite,
    output logic [15:0] progAddr,
    output logic [7:0] progData,
    output logic secProgram,
    output fla_sec_s secWrite,
    output logic eraseCodeDataPar,
    output logic eraseCodeDataSer
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {ppWrite, sdWrite, secProgram, eraseCodeDataPar, eraseCodeDataSer} = '0;
        progAddr = '0;
        progData = '0;
        secWrite = '0;
    end
    // Address held after the pulse so parallel reads can follow
    task automatic prog(input logic par, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        ppWrite <= par;
        sdWrite <= !par;
        progAddr <= a;
        progData <= d;
        @(posedge clk);
        {ppWrite, sdWrite} <= 2'b00;
        progData <= ~d;
    endtask
    task automatic set_sec(input fla_sec_s s);
        @(posedge clk);
        secProgram <= 1'b1;
        secWrite <= s;
        @(posedge clk);
        secProgram <= 1'b0;
        secWrite <= ~s;
    endtask
    task automatic erase(input logic par);
        @(posedge clk);
        eraseCodeDataPar <= par;
        eraseCodeDataSer <= !par;
        @(posedge clk);
        {eraseCodeDataPar, eraseCodeDataSer} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ===== sim/flash_user_download_and_security_tb_top.sv
`default_nettype none
module flash_user_download_and_security_tb_top import fla_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, busy, uloadActive, strobe_n, sde, ppW, sdW, secP, erP, erS, fExt;
    fla_sfr_s sfrReq;
    fla_sec_s secState, secW;
    logic [7:0] sfrRdata, pData, ppRdata, fetchData, v;
    logic [15:0] pAddr, fetchAddr;
    logic ul8;
    int miscompares = 0;
    int n_checks = 0;
    logic [19:0] rows [] = '{20'h00006, 20'h00503, 20'h006ff, 20'h00111, 20'h00222,
        20'h00333, 20'h00444, 20'h00002, 20'h00100, 20'h00001, 20'h10111, 20'h10444,
        20'h00004, 20'h10000, 20'h00255, 20'h00004, 20'h10001, 20'h0050f, 20'h006fd,
        20'h00081, 20'h10122, 20'h00503, 20'h006ff, 20'h00005, 20'h00001, 20'h101ff,
        20'h104ff, 20'h10700, 20'h00500, 20'h00600, 20'h0015a, 20'h00082, 20'h00001,
        20'h1015a, 20'h102ff};
    fla_flash_ctrl dut (.clk(clk), .reset_n(reset_n), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata), .busy(busy), .uloadActive(uloadActive),
        .program_store_strobe_n(strobe_n), .serialDownloadEntry(sde),
        .secProgram(secP), .secWrite(secW), .secState(secState),
        .eraseCodeDataPar(erP), .eraseCodeDataSer(erS), .ppWrite(ppW),
        .ppAddr(pAddr), .ppWdata(pData), .ppRdata(ppRdata), .sdWrite(sdW),
        .sdAddr(pAddr), .sdWdata(pData), .fetchAddr(fetchAddr),
        .fetchExternal(fExt), .fetchData(fetchData));
    fla_flash_ctrl #(.MEM_VARIANT(FLA_VAR_8K)) dut8 (.clk(clk), .reset_n(reset_n),
        .sfrReq(sfrReq), .sfrRdata(), .busy(), .uloadActive(ul8),
        .program_store_strobe_n(strobe_n), .serialDownloadEntry(), .secProgram(secP),
        .secWrite(secW), .secState(), .eraseCodeDataPar(erP), .eraseCodeDataSer(erS),
        .ppWrite(ppW), .ppAddr(pAddr), .ppWdata(pData), .ppRdata(), .sdWrite(sdW),
        .sdAddr(pAddr), .sdWdata(pData), .fetchAddr(fetchAddr), .fetchExternal(fExt),
        .fetchData());
    fla_prog_model pm (.clk(clk), .ppWrite(ppW), .sdWrite(sdW), .progAddr(pAddr),
        .progData(pData), .secProgram(secP), .secWrite(secW),
        .eraseCodeDataPar(erP), .eraseCodeDataSer(erS));
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded poll; a busy that outlives the limit counts as a mismatch
    task automatic idle(input int lim);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (busy !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, busy}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        sfrReq.write <= 1'b0;
        sfrReq.wdata <= ~d;
        idle(5000);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfrReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        sfrReq.read <= 1'b0;
        @(posedge clk);
        #1;
        d = sfrRdata;
    endtask
    task automatic fch(input logic [15:0] a, input logic ext, input logic [7:0] e);
        @(posedge clk);
        fetchAddr <= a;
        fExt <= ext;
        repeat (2) @(posedge clk);
        #1;
        chk(fetchData, e);
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {reset_n, strobe_n, fExt, fetchAddr} = {1'b0, 1'b0, 1'b0, 16'h0000};
        sfrReq = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({2'b00, busy, uloadActive, sde, secState}, 8'h00);
        chk(sfrRdata, FLA_REG_RESET);
        pm.prog(1'b0, 16'h1000, 8'hff);
        pm.prog(1'b0, 16'he000, 8'hff);
        pm.prog(1'b0, 16'h0000, 8'h3c);
        chk({7'h00, sde}, 8'h01);
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i][16]) begin
                rd(rows[i][15:8], v);
                chk(v, rows[i][7:0]);
            end else
                wr(rows[i][15:8], rows[i][7:0]);
        end
        fch(16'h0000, 1'b0, 8'h3c);
        $display("register rows done");
        wr(FLA_SFR_CMD, FLA_CMD_ENTER_UL);
        chk({7'h00, uloadActive}, 8'h01);
        chk({7'h00, ul8}, 8'h00);
        wr(FLA_SFR_ADDRH, 8'h10);
        wr(FLA_SFR_ADDRL, 8'h00);
        wr(FLA_SFR_DATA1, 8'h5a);
        wr(FLA_SFR_CMD, FLA_CMD_WRITE_BYTE);
        fch(16'h1000, 1'b0, 8'h5a);
        wr(FLA_SFR_ADDRH, 8'he0);
        wr(FLA_SFR_CMD, FLA_CMD_WRITE_BYTE);
        fch(16'he000, 1'b0, 8'hff);
        wr(FLA_SFR_CMD, FLA_CMD_LEAVE_UL);
        chk({7'h00, uloadActive}, 8'h00);
        $display("download mode test done");
        pm.set_sec('{1'b1, 1'b0, 1'b0});
        pm.prog(1'b1, 16'h0000, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk(ppRdata, 8'h3c);
        fch(16'h0000, 1'b1, 8'h3c);
        pm.set_sec('{1'b0, 1'b1, 1'b1});
        repeat (2) @(posedge clk);
        #1;
        chk({5'h00, secState}, 8'h07);
        chk(ppRdata, 8'h00);
        fch(16'h0000, 1'b1, 8'h00);
        fch(16'h0000, 1'b0, 8'h3c);
        pm.erase(1'b0);
        idle(70000);
        @(posedge clk);
        #1;
        chk({5'h00, secState}, 8'h01);
        fch(16'h1000, 1'b0, 8'hff);
        $display("security test done");
        @(posedge clk);
        strobe_n <= 1'b0;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({4'h0, sde, secState}, 8'h01);
        $display("strap test done");
        wrap_up();
    end
endmodule
`default_nettype wire
